//--- asrc_pkg.sv
`default_nettype none
package asrc_pkg;

   localparam int unsigned DATA_W   = 24;
   localparam int unsigned CFG_W    = 8;
   localparam int unsigned PHASE_W  = 12;
   localparam int unsigned SETTLE_W = 3;

   // reset bit position inside second_config_register
   localparam int unsigned RESET_BIT_POS = 0;

   // conversion results dropped while the decimation filter settles
   localparam logic [SETTLE_W-1:0] SETTLE_CONV = 3'h3;
   // settle count value at which the last dropped result arrives
   localparam logic [SETTLE_W-1:0] SETTLE_LAST = 3'h1;

   localparam logic [DATA_W-1:0]   DATA_RST  = 24'h000000;
   localparam logic [PHASE_W-1:0]  PHASE_RST = 12'h000;
   localparam logic [SETTLE_W-1:0] SETTLE_RST = 3'h0;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_RESET,
      ST_SETTLE
   } asrc_state_t;

   // write of the second_config_register from the serial interface
   typedef struct packed {
      logic             wr;
      logic [CFG_W-1:0] data;
   } asrc_cfg_t;

   // phase delay write, in master clock ticks
   typedef struct packed {
      logic               wr;
      logic [PHASE_W-1:0] delay;
   } asrc_phase_t;

   // one result from the decimation filter
   typedef struct packed {
      logic              valid;
      logic [DATA_W-1:0] data;
   } asrc_conv_t;

   // channel outputs
   typedef struct packed {
      logic               dataReady;
      logic [DATA_W-1:0]  convData;
      logic               inSoftReset;
      logic               sampleClkEn;
      logic [PHASE_W-1:0] phaseDelay;
   } asrc_out_t;

endpackage : asrc_pkg

`default_nettype wire

//--- asrc_soft_reset.sv
`timescale 1ns/1ps
`default_nettype none

module asrc_soft_reset (
   input  wire logic                  clk,
   input  wire logic                  srst,
   input  wire logic                  spiMode,
   input  wire logic                  mclkEn,
   input  wire asrc_pkg::asrc_cfg_t   cfgIn,
   input  wire asrc_pkg::asrc_phase_t phaseIn,
   input  wire asrc_pkg::asrc_conv_t  convIn,
   output var  asrc_pkg::asrc_out_t   chanOut
);
   import asrc_pkg::*;

   typedef struct packed {
      asrc_state_t         state;
      logic [SETTLE_W-1:0] settleCnt;
      logic                pending;
      logic [DATA_W-1:0]   pendData;
      logic [PHASE_W-1:0]  phaseCnt;
      asrc_out_t           out;
   } asrc_regs_t;

   asrc_regs_t st_r;
   asrc_regs_t st_nxt;

   logic resetWr;
   logic resetBit;

   always_comb begin
      resetWr  = cfgIn.wr && spiMode;
      resetBit = cfgIn.data[RESET_BIT_POS];
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.out.dataReady = 1'b0;
      // input structure keeps clocking in every state
      st_nxt.out.sampleClkEn = mclkEn;
      // phase delay survives soft reset untouched
      if (phaseIn.wr) begin
         st_nxt.out.phaseDelay = phaseIn.delay;
      end
      case (st_r.state)
         ST_RUN: begin
            if (resetWr && resetBit) begin
               st_nxt.state = ST_RESET;
               st_nxt.pending = 1'b0;
               st_nxt.out.convData = DATA_RST;
               st_nxt.out.inSoftReset = 1'b1;
            end else begin
               if (st_r.pending && mclkEn) begin
                  if (st_r.phaseCnt == PHASE_RST) begin
                     st_nxt.pending = 1'b0;
                     st_nxt.out.convData = st_r.pendData;
                     st_nxt.out.dataReady = 1'b1;
                  end else begin
                     st_nxt.phaseCnt = st_r.phaseCnt - 1'b1;
                  end
               end
               // a newer result replaces a pending one and restarts the count
               if (convIn.valid) begin
                  st_nxt.pending = 1'b1;
                  st_nxt.pendData = convIn.data;
                  st_nxt.phaseCnt = st_r.out.phaseDelay;
               end
            end
         end
         ST_RESET: begin
            // converter runs on but its result is held at zero
            st_nxt.out.convData = DATA_RST;
            st_nxt.pending = 1'b0;
            if (resetWr && !resetBit) begin
               st_nxt.state = ST_SETTLE;
               st_nxt.settleCnt = SETTLE_CONV;
               st_nxt.out.inSoftReset = 1'b0;
            end
         end
         ST_SETTLE: begin
            if (resetWr && resetBit) begin
               st_nxt.state = ST_RESET;
               st_nxt.out.convData = DATA_RST;
               st_nxt.out.inSoftReset = 1'b1;
            end else if (convIn.valid) begin
               // drop results until the filter has settled, then resume
               st_nxt.settleCnt = st_r.settleCnt - 1'b1;
               if (st_r.settleCnt == SETTLE_LAST) begin
                  st_nxt.state = ST_RUN;
               end
            end
         end
         default: begin
            st_nxt.state = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_r.state           <= ST_RUN;
         st_r.settleCnt       <= SETTLE_RST;
         st_r.pending         <= 1'b0;
         st_r.pendData        <= DATA_RST;
         st_r.phaseCnt        <= PHASE_RST;
         st_r.out.dataReady   <= 1'b0;
         st_r.out.convData    <= DATA_RST;
         st_r.out.inSoftReset <= 1'b0;
         st_r.out.sampleClkEn <= 1'b0;
         st_r.out.phaseDelay  <= PHASE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   always_comb begin
      chanOut = st_r.out;
   end

   enter_only_spi_a: assert property (
      @(posedge clk) disable iff (srst)
      (cfgIn.wr && !spiMode && !chanOut.inSoftReset)
      |=> !chanOut.inSoftReset)
      else $error("soft reset entered outside spi mode");

   enter_on_write_a: assert property (
      @(posedge clk) disable iff (srst)
      (st_r.state == ST_RUN && cfgIn.wr && spiMode
       && cfgIn.data[RESET_BIT_POS])
      |=> chanOut.inSoftReset && st_r.state == ST_RESET)
      else $error("reset bit write did not enter soft reset");

   data_held_zero_a: assert property (
      @(posedge clk) disable iff (srst)
      chanOut.inSoftReset |-> chanOut.convData == DATA_RST)
      else $error("data not zero during soft reset");

   entry_clears_a: assert property (
      @(posedge clk) disable iff (srst)
      $rose(chanOut.inSoftReset)
      |-> chanOut.convData == DATA_RST
          && ($past(phaseIn.wr) || $stable(chanOut.phaseDelay)))
      else $error("entry did not clear only the data register");

   settle_done_a: assert property (
      @(posedge clk) disable iff (srst)
      (st_r.state == ST_SETTLE && st_r.settleCnt == SETTLE_LAST
       && convIn.valid && !resetWr)
      |=> st_r.state == ST_RUN)
      else $error("did not resume after settling");

   no_drdy_reset_a: assert property (
      @(posedge clk) disable iff (srst)
      (chanOut.inSoftReset || st_r.state == ST_SETTLE)
      |-> !chanOut.dataReady)
      else $error("data ready during soft reset");

   phase_kept_a: assert property (
      @(posedge clk) disable iff (srst)
      (chanOut.inSoftReset && !phaseIn.wr) |=> $stable(chanOut.phaseDelay))
      else $error("phase delay lost in soft reset");

   clock_passed_a: assert property (
      @(posedge clk) disable iff (srst)
      mclkEn |=> chanOut.sampleClkEn)
      else $error("master clock not passed to input structure");

   clock_gap_a: assert property (
      @(posedge clk) disable iff (srst)
      !mclkEn |=> !chanOut.sampleClkEn)
      else $error("input structure clocked without master clock");

   leave_on_write_a: assert property (
      @(posedge clk) disable iff (srst)
      (st_r.state == ST_RESET && cfgIn.wr && spiMode
       && !cfgIn.data[RESET_BIT_POS])
      |=> !chanOut.inSoftReset && st_r.state == ST_SETTLE)
      else $error("reset bit clear did not leave soft reset");

   reset_holds_a: assert property (
      @(posedge clk) disable iff (srst)
      (chanOut.inSoftReset && !(cfgIn.wr && spiMode))
      |=> chanOut.inSoftReset)
      else $error("soft reset left without a write");

   pending_dropped_a: assert property (
      @(posedge clk) disable iff (srst)
      chanOut.inSoftReset |-> !st_r.pending)
      else $error("result kept pending during soft reset");

   data_changes_a: assert property (
      @(posedge clk) disable iff (srst)
      ($changed(chanOut.convData) && !$past(srst))
      |-> chanOut.dataReady || chanOut.inSoftReset)
      else $error("data register changed without a result");

   settle_entry_a: assert property (
      @(posedge clk) disable iff (srst)
      ($fell(chanOut.inSoftReset) && !$past(srst))
      |-> st_r.state == ST_SETTLE && st_r.settleCnt == SETTLE_CONV)
      else $error("soft reset exit did not start settling");

   drdy_in_run_a: assert property (
      @(posedge clk) disable iff (srst)
      chanOut.dataReady |-> $past(st_r.state) == ST_RUN)
      else $error("data ready outside run state");

   result_after_tick_a: assert property (
      @(posedge clk) disable iff (srst)
      chanOut.dataReady |-> $past(st_r.pending) && $past(mclkEn))
      else $error("data ready without a pending result and tick");

   phase_loaded_a: assert property (
      @(posedge clk) disable iff (srst)
      (st_r.state == ST_RUN && convIn.valid && !(resetWr && resetBit))
      |=> st_r.pending && st_r.phaseCnt == $past(chanOut.phaseDelay))
      else $error("phase count not loaded from phase delay");

   phase_write_a: assert property (
      @(posedge clk) disable iff (srst)
      phaseIn.wr |=> chanOut.phaseDelay == $past(phaseIn.delay))
      else $error("phase delay write not taken");

endmodule : asrc_soft_reset

`default_nettype wire

//--- asrc_host.sv
`timescale 1ns/1ps
`default_nettype none
module asrc_host (
   input  wire logic                 clk,
   output var  asrc_pkg::asrc_cfg_t  cfg,
   output var  logic                 spi
);
   import asrc_pkg::*;
   initial begin
      cfg = '0;
      spi = 1'b1;
   end
   // one write of second_config_register, mode held through the write
   task automatic wr_cfg(input logic b, input logic mode);
      @(posedge clk);
      #1;
      spi = mode;
      cfg = '{wr: 1'b1, data: {7'h00, b}};
      @(posedge clk);
      #1;
      cfg = '{wr: 1'b0, data: 8'hFF};
      spi = 1'b1;
   endtask : wr_cfg
endmodule : asrc_host
`default_nettype wire

//--- test_adc_soft_reset.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_soft_reset;
   import asrc_pkg::*;
   logic               clk;
   logic               srst;
   logic               mclkEn = 1'b0;
   logic               mclkSeen = 1'b0;
   logic               spiMode;
   asrc_cfg_t          cfgIn;
   asrc_phase_t        phaseIn;
   asrc_conv_t         convIn;
   asrc_out_t          chanOut;
   int                 err_total;
   int                 tests_run;
   int                 seen;
   int                 lat;
   logic [DATA_W-1:0]  d;
   logic [DATA_W-1:0]  got;
   logic [PHASE_W-1:0] p;
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   asrc_host HOST (.clk(clk), .cfg(cfgIn), .spi(spiMode));
   asrc_soft_reset DUT (.clk(clk), .srst(srst), .spiMode(spiMode),
      .mclkEn(mclkEn), .cfgIn(cfgIn), .phaseIn(phaseIn), .convIn(convIn),
      .chanOut(chanOut));
   always @(posedge clk) mclkEn <= #1 ~mclkEn;
   // master clock tick as the block saw it at the last edge
   always @(posedge clk) mclkSeen <= mclkEn;
   // data ready follows the (delay+1)th master clock tick after a result
   function automatic logic [DATA_W-1:0] exp_lat(
      input logic [PHASE_W-1:0] ph);
      return DATA_W'(ph) + 24'h000001;
   endfunction : exp_lat
   task automatic chk_v(input logic [DATA_W-1:0] g,
                        input logic [DATA_W-1:0] e);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk_v
   task automatic close_out;
      if (err_total == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : close_out
   // one filter result, then count data-ready pulses in a bounded span
   task automatic conv(input logic [DATA_W-1:0] v);
      int ticks;
      @(posedge clk);
      #1;
      convIn = '{valid: 1'b1, data: v};
      @(posedge clk);
      #1;
      convIn = '{valid: 1'b0, data: ~v};
      seen = 0;
      ticks = 0;
      lat = 0;
      repeat (30) begin
         @(posedge clk);
         #1;
         if (seen == 0 && mclkSeen === 1'b1)
            ticks++;
         if (chanOut.dataReady === 1'b1) begin
            seen++;
            got = chanOut.convData;
            lat = ticks;
         end
      end
   endtask : conv
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      close_out;
   end
   initial begin
      srst = 1'b1;
      phaseIn = '0;
      convIn = '0;
      err_total = 0;
      tests_run = 0;
      void'($urandom(81));
      repeat (12) @(posedge clk);
      #1;
      srst = 1'b0;
      p = PHASE_W'($urandom_range(1, 8));
      phaseIn = '{wr: 1'b1, delay: p};
      @(posedge clk);
      #1;
      phaseIn.wr = 1'b0;
      d = DATA_W'($urandom);
      conv(d);
      chk_v(DATA_W'(seen), 24'h000001);
      chk_v(got, d);
      chk_v(DATA_W'(lat), exp_lat(p));
      HOST.wr_cfg(1'b1, 1'b0);
      chk_v(DATA_W'(chanOut.inSoftReset), 24'h000000);
      HOST.wr_cfg(1'b1, 1'b1);
      chk_v(DATA_W'(chanOut.inSoftReset), 24'h000001);
      chk_v(chanOut.convData, 24'h000000);
      chk_v(DATA_W'(chanOut.sampleClkEn), DATA_W'(mclkSeen));
      conv(DATA_W'($urandom));
      chk_v(DATA_W'(seen), 24'h000000);
      chk_v(chanOut.convData, 24'h000000);
      chk_v(DATA_W'(chanOut.sampleClkEn), DATA_W'(mclkSeen));
      HOST.wr_cfg(1'b0, 1'b1);
      chk_v(DATA_W'(chanOut.inSoftReset), 24'h000000);
      for (int i = 0; i < 4; i++) begin
         d = DATA_W'($urandom);
         conv(d);
         chk_v(DATA_W'(seen), DATA_W'(i == 3));
      end
      chk_v(got, d);
      chk_v(DATA_W'(lat), exp_lat(p));
      chk_v(DATA_W'(chanOut.phaseDelay), DATA_W'(p));
      close_out;
   end
endmodule : test_adc_soft_reset
`default_nettype wire
